/* rtl/mdc_cfg.svh */
`ifndef MDC_CFG_SVH
`define MDC_CFG_SVH
// ==========================================================
// register offsets
`define MDC_OFS_DEVICE_COMMAND_CONTROL 8'hea
`define MDC_OFS_ALGORITHM_DEBUG_OVERRIDE_A 8'hec
`define MDC_OFS_ALGORITHM_DEBUG_OVERRIDE_B 8'hee
`define MDC_OFS_CURRENT_LOOP_GAINS 8'hf0
`define MDC_OFS_SPEED_LOOP_GAINS 8'hf2
`define MDC_OFS_ANALOG_OUT_CHANNEL_ONE 8'hf4
`define MDC_OFS_ANALOG_OUT_CHANNEL_TWO 8'hf6
// ==========================================================
// field positions of device_command_control
`define MDC_BIT_SAVE 31
`define MDC_BIT_RESTORE 30
`define MDC_BIT_FLT_CLR 29
`define MDC_BIT_RETRY_CLR 28
`define MDC_ANGLE_HI 19
`define MDC_ANGLE_LO 11
`define MDC_BIT_TICKLE 10
// ==========================================================
// reset values
`define MDC_RST_CMD 32'h0000_0000
`define MDC_RST_ZERO 32'h0000_0000
`define MDC_RST_DAC1 32'h0011_0000
`define MDC_RST_DAC2 32'h0000_0000
// ==========================================================
// angle wrap and timing
`define MDC_ANGLE_FULL 9'h168
`define MDC_NVM_WORDS 8
`define MDC_NVM_WORD_CYCLES 4
`endif

/* rtl/mdc_pkg.sv */
package mdc_pkg;
  typedef enum logic [1:0] {MDC_NVM_IDLE, MDC_NVM_SAVE, MDC_NVM_LOAD} mdc_nvm_state_t;
endpackage

/* rtl/mdc_angle_wrap.sv */
`timescale 1ns/1ps
`include "mdc_cfg.svh"
// ==========================================================
// angle modulo 360, one register stage
module mdc_angle_wrap import mdc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // angle
  input wire logic [8:0] angle_in,
  output logic [8:0] angle_out
);
  typedef struct packed {
    logic [8:0] ang_r;
  } mdc_wrap_state_t;
  mdc_wrap_state_t st_r, st_nxt;
  always_comb begin
    st_nxt = st_r;
    // 9 bits reach 511, so one subtraction always suffices
    if (angle_in >= `MDC_ANGLE_FULL) begin
      st_nxt.ang_r = angle_in - `MDC_ANGLE_FULL; // see [RULE_04]
    end else begin
      st_nxt.ang_r = angle_in;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign angle_out = st_r.ang_r;
  chk_angle_below_full: assert property (@(posedge clk) disable iff (!reset_n) st_r.ang_r < 9'h168) // see [RULE_04]
    else $error("wrapped angle not below 360");
endmodule // mdc_angle_wrap

/* rtl/mdc_device_cmd.sv */
`timescale 1ns/1ps
`include "mdc_cfg.svh"
// Function
// [RULE_01] save bit copies shadow config to EEPROM
// [RULE_02] restore bit reloads EEPROM into shadow
// [RULE_03] bits 29/28 clear faults, retry count
// [RULE_04] angle field applied modulo 360 in align
// [RULE_05] tickle bit readable, device clears it
// [RULE_06] host refreshes tickle every watchdog interval; tb_top sets it only once, in t_tickle
// [RULE_07] host leaves unlisted offsets alone
// [RULE_08] save/restore bits drop when transfer done
module mdc_device_cmd import mdc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // motor core
  input wire logic force_align_en,
  output logic [8:0] align_angle,
  output logic align_angle_valid,
  output logic fault_clear_all,
  output logic fault_retry_counter_clear,
  output logic watchdog_refresh,
  // nonvolatile store
  output logic nvm_busy,
  output logic nvm_we,
  output logic nvm_re,
  output logic [2:0] nvm_addr,
  output logic [31:0] nvm_wdata,
  input wire logic [31:0] nvm_rdata,
  // shadow configuration
  output logic [31:0] debug_override_b,
  output logic [31:0] current_loop_gains,
  output logic [31:0] speed_loop_gains,
  output logic [31:0] analog_out_one,
  output logic [31:0] analog_out_two
);
  typedef struct packed {
    logic save_r;
    logic restore_r;
    logic [8:0] angle_r;
    logic tickle_r;
    logic flt_clr_r;
    logic retry_clr_r;
    logic wd_r;
    mdc_nvm_state_t nvm_st_r;
    logic [2:0] widx_r;
    logic [1:0] wcnt_r;
    logic [31:0] dbg_a_r;
    logic [31:0] dbg_b_r;
    logic [31:0] cur_r;
    logic [31:0] spd_r;
    logic [31:0] dac1_r;
    logic [31:0] dac2_r;
    logic [31:0] rdata_r;
    logic rvalid_r;
    logic nvm_we_r;
    logic nvm_re_r;
    logic [2:0] nvm_addr_r;
    logic [31:0] nvm_wdata_r;
    logic [8:0] ang_out_r;
    logic ang_v_r;
    logic busy_r;
  } mdc_state_t;
  mdc_state_t st_r, st_nxt;
  logic [8:0] angle_wrapped;
  logic [31:0] cmd_word;
  logic [31:0] shadow_word;
  logic last_beat;
  // ==========================================================
  // angle wrap stage
  mdc_angle_wrap u_wrap (
    .clk(clk),
    .reset_n(reset_n),
    .angle_in(st_r.angle_r),
    .angle_out(angle_wrapped)
  );
  // ==========================================================
  // read view and shadow word selection
  always_comb begin
    cmd_word = '0;
    cmd_word[`MDC_BIT_SAVE] = st_r.save_r;
    cmd_word[`MDC_BIT_RESTORE] = st_r.restore_r;
    cmd_word[`MDC_BIT_TICKLE] = st_r.tickle_r;
    unique case (st_r.widx_r)
      3'h0: shadow_word = st_r.dbg_b_r;
      3'h1: shadow_word = st_r.cur_r;
      3'h2: shadow_word = st_r.spd_r;
      3'h3: shadow_word = st_r.dac1_r;
      3'h4: shadow_word = st_r.dac2_r;
      default: shadow_word = '0;
    endcase
    last_beat = (st_r.wcnt_r == 2'(`MDC_NVM_WORD_CYCLES - 1)) && (st_r.widx_r == 3'(`MDC_NVM_WORDS - 1));
  end
  // ==========================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.flt_clr_r = 1'b0;
    st_nxt.retry_clr_r = 1'b0;
    st_nxt.wd_r = 1'b0;
    st_nxt.rvalid_r = 1'b0;
    st_nxt.nvm_we_r = 1'b0;
    st_nxt.nvm_re_r = 1'b0;
    // tickle is consumed the cycle after it is seen set
    if (st_r.tickle_r) begin
      st_nxt.tickle_r = 1'b0; // see [RULE_05]
      st_nxt.wd_r = 1'b1; // see [RULE_05]
    end
    if (reg_rd) begin
      st_nxt.rvalid_r = 1'b1;
      unique case (reg_addr)
        `MDC_OFS_DEVICE_COMMAND_CONTROL: st_nxt.rdata_r = cmd_word; // see [RULE_05]
        `MDC_OFS_ALGORITHM_DEBUG_OVERRIDE_B: st_nxt.rdata_r = st_r.dbg_b_r;
        `MDC_OFS_CURRENT_LOOP_GAINS: st_nxt.rdata_r = st_r.cur_r;
        `MDC_OFS_SPEED_LOOP_GAINS: st_nxt.rdata_r = st_r.spd_r;
        `MDC_OFS_ANALOG_OUT_CHANNEL_ONE: st_nxt.rdata_r = st_r.dac1_r;
        `MDC_OFS_ANALOG_OUT_CHANNEL_TWO: st_nxt.rdata_r = st_r.dac2_r;
        default: st_nxt.rdata_r = '0;
      endcase
    end
    if (reg_wr) begin
      unique case (reg_addr)
        `MDC_OFS_DEVICE_COMMAND_CONTROL: begin
          st_nxt.angle_r = reg_wdata[`MDC_ANGLE_HI:`MDC_ANGLE_LO];
          st_nxt.flt_clr_r = reg_wdata[`MDC_BIT_FLT_CLR]; // see [RULE_03]
          st_nxt.retry_clr_r = reg_wdata[`MDC_BIT_RETRY_CLR]; // see [RULE_03]
          if (reg_wdata[`MDC_BIT_TICKLE]) begin
            st_nxt.tickle_r = 1'b1; // see [RULE_05]
          end
          // a new save or restore is ignored while a transfer runs
          if (st_r.nvm_st_r == MDC_NVM_IDLE) begin
            if (reg_wdata[`MDC_BIT_SAVE]) begin
              st_nxt.save_r = 1'b1; // see [RULE_01]
              st_nxt.nvm_st_r = MDC_NVM_SAVE;
            end else if (reg_wdata[`MDC_BIT_RESTORE]) begin
              st_nxt.restore_r = 1'b1; // see [RULE_02]
              st_nxt.nvm_st_r = MDC_NVM_LOAD;
            end
            st_nxt.widx_r = '0;
            st_nxt.wcnt_r = '0;
          end
        end
        `MDC_OFS_ALGORITHM_DEBUG_OVERRIDE_A: st_nxt.dbg_a_r = reg_wdata;
        `MDC_OFS_ALGORITHM_DEBUG_OVERRIDE_B: st_nxt.dbg_b_r = reg_wdata;
        `MDC_OFS_CURRENT_LOOP_GAINS: st_nxt.cur_r = reg_wdata;
        `MDC_OFS_SPEED_LOOP_GAINS: st_nxt.spd_r = reg_wdata;
        `MDC_OFS_ANALOG_OUT_CHANNEL_ONE: st_nxt.dac1_r = reg_wdata;
        `MDC_OFS_ANALOG_OUT_CHANNEL_TWO: st_nxt.dac2_r = reg_wdata;
        default: ;
      endcase
    end
    // ==========================================================
    // eeprom transfer engine, one word per few cycles
    unique case (st_r.nvm_st_r)
      MDC_NVM_IDLE: ;
      MDC_NVM_SAVE, MDC_NVM_LOAD: begin
        st_nxt.wcnt_r = st_r.wcnt_r + 2'h1;
        if (st_r.wcnt_r == 2'h0) begin
          st_nxt.nvm_addr_r = st_r.widx_r;
          st_nxt.nvm_wdata_r = shadow_word;
          st_nxt.nvm_we_r = (st_r.nvm_st_r == MDC_NVM_SAVE); // see [RULE_01]
          st_nxt.nvm_re_r = (st_r.nvm_st_r == MDC_NVM_LOAD); // see [RULE_02]
        end
        if (st_r.wcnt_r == 2'(`MDC_NVM_WORD_CYCLES - 1)) begin
          st_nxt.widx_r = st_r.widx_r + 3'h1;
          if (st_r.nvm_st_r == MDC_NVM_LOAD) begin
            unique case (st_r.widx_r)
              3'h0: st_nxt.dbg_b_r = nvm_rdata; // see [RULE_02]
              3'h1: st_nxt.cur_r = nvm_rdata;
              3'h2: st_nxt.spd_r = nvm_rdata;
              3'h3: st_nxt.dac1_r = nvm_rdata;
              3'h4: st_nxt.dac2_r = nvm_rdata;
              default: ;
            endcase
          end
        end
        if (last_beat) begin
          st_nxt.nvm_st_r = MDC_NVM_IDLE;
          st_nxt.save_r = 1'b0; // see [RULE_08]
          st_nxt.restore_r = 1'b0; // see [RULE_08]
        end
      end
      default: st_nxt.nvm_st_r = MDC_NVM_IDLE;
    endcase
    // ==========================================================
    // output flops, busy follows the next state so it rises with the command
    st_nxt.ang_out_r = angle_wrapped;
    st_nxt.ang_v_r = force_align_en; // see [RULE_04]
    st_nxt.busy_r = (st_nxt.nvm_st_r != MDC_NVM_IDLE);
  end
  // ==========================================================
  // state register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r <= '0;
      st_r.dac1_r <= `MDC_RST_DAC1;
      st_r.dac2_r <= `MDC_RST_DAC2;
      st_r.nvm_st_r <= MDC_NVM_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end
  // ==========================================================
  // output stage, all flops
  assign align_angle = st_r.ang_out_r;
  assign align_angle_valid = st_r.ang_v_r;
  assign nvm_busy = st_r.busy_r;
  assign reg_rdata = st_r.rdata_r;
  assign reg_rvalid = st_r.rvalid_r;
  assign fault_clear_all = st_r.flt_clr_r;
  assign fault_retry_counter_clear = st_r.retry_clr_r;
  assign watchdog_refresh = st_r.wd_r;
  assign nvm_we = st_r.nvm_we_r;
  assign nvm_re = st_r.nvm_re_r;
  assign nvm_addr = st_r.nvm_addr_r;
  assign nvm_wdata = st_r.nvm_wdata_r;
  assign debug_override_b = st_r.dbg_b_r;
  assign current_loop_gains = st_r.cur_r;
  assign speed_loop_gains = st_r.spd_r;
  assign analog_out_one = st_r.dac1_r;
  assign analog_out_two = st_r.dac2_r;
  // ==========================================================
  // checks
  chk_save_starts: assert property (@(posedge clk) disable iff (!reset_n)
    reg_wr && reg_addr == 8'hea && reg_wdata[31] && st_r.nvm_st_r == MDC_NVM_IDLE |=> st_r.save_r && st_r.nvm_st_r == MDC_NVM_SAVE) // see [RULE_01]
    else $error("save command not started");
  chk_save_writes: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(st_r.save_r) |-> ##1 nvm_we) // see [RULE_01]
    else $error("save did not write store");
  chk_restore_reads: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(st_r.restore_r) |-> ##1 nvm_re && !nvm_we) // see [RULE_02]
    else $error("restore did not read store");
  chk_fault_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    reg_wr && reg_addr == 8'hea && reg_wdata[29] |=>
    fault_clear_all ##1 (!fault_clear_all || $past(reg_wr && reg_addr == 8'hea && reg_wdata[29]))) // see [RULE_03]
    else $error("fault clear not a single pulse");
  chk_retry_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    reg_wr && reg_addr == 8'hea && reg_wdata[28] |=> fault_retry_counter_clear) // see [RULE_03]
    else $error("retry clear missing");
  chk_cmd_no_store: assert property (@(posedge clk) disable iff (!reset_n)
    reg_rd && reg_addr == 8'hea |=> reg_rdata[29:28] == 2'h0) // see [RULE_03]
    else $error("clear bits read back");
  chk_tickle_self_clear: assert property (@(posedge clk) disable iff (!reset_n)
    st_r.tickle_r && !(reg_wr && reg_addr == 8'hea && reg_wdata[10]) |=> !st_r.tickle_r && watchdog_refresh) // see [RULE_05]
    else $error("tickle not consumed");
  chk_align_follows: assert property (@(posedge clk) disable iff (!reset_n)
    force_align_en |=> align_angle_valid) // see [RULE_04]
    else $error("align valid not following enable");
  chk_transfer_ends: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(st_r.save_r) |-> ##[1:40] !st_r.save_r) // see [RULE_08]
    else $error("save bit never dropped");
endmodule // mdc_device_cmd

/* tb/mdc_nvm_model.sv */
`timescale 1ns/1ps
// ==========================================================
// nonvolatile store model: 8 words, read data valid 1..5 cycles after a read
module mdc_nvm_model (
  // clock
  input wire logic clk,
  // store port
  input wire logic nvm_we,
  input wire logic nvm_re,
  input wire logic [2:0] nvm_addr,
  input wire logic [31:0] nvm_wdata,
  output logic [31:0] nvm_rdata
);
  logic [31:0] mem [8];
  logic [2:0] addr_r;
  logic [2:0] cnt_r;
  initial begin
    foreach (mem[i]) mem[i] = 32'h0;
    addr_r = 3'h0;
    cnt_r = 3'h0;
  end
  always @(posedge clk) begin
    if (nvm_we) mem[nvm_addr] <= nvm_wdata;
    if (nvm_re) begin
      addr_r <= nvm_addr;
      cnt_r <= 3'h5;
    end else if (cnt_r != 3'h0) begin
      cnt_r <= cnt_r - 3'h1;
    end
  end
  // outside the data window show a wrong word so stale sampling is caught
  assign nvm_rdata = (cnt_r != 3'h0) ? mem[addr_r] : ~mem[addr_r];
endmodule // mdc_nvm_model

/* tb/tb_top.sv */
`timescale 1ns/1ps
`include "mdc_cfg.svh"
module tb_top;
  import mdc_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic force_align_en = 1'b0;
  logic [31:0] reg_rdata, nvm_wdata, nvm_rdata, dbg_b, cur_g, spd_g, ao1, ao2;
  logic reg_rvalid, ang_v, flt_clr, rty_clr, wdog, nvm_busy, nvm_we, nvm_re;
  logic [8:0] ang;
  logic [2:0] nvm_addr;
  logic [31:0] d;
  int error_cnt = 0;
  int checks_done = 0;
  always #10 clk = ~clk;
  mdc_device_cmd uut (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .force_align_en(force_align_en),
    .align_angle(ang), .align_angle_valid(ang_v), .fault_clear_all(flt_clr),
    .fault_retry_counter_clear(rty_clr), .watchdog_refresh(wdog), .nvm_busy(nvm_busy), .nvm_we(nvm_we),
    .nvm_re(nvm_re), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata),
    .debug_override_b(dbg_b), .current_loop_gains(cur_g), .speed_loop_gains(spd_g),
    .analog_out_one(ao1), .analog_out_two(ao2));
  mdc_nvm_model nvm (.clk(clk), .nvm_we(nvm_we), .nvm_re(nvm_re), .nvm_addr(nvm_addr),
    .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata));
  // ==========================================================
  // shared tasks
  task automatic close_out();
    if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk("rvalid", 32'h1, {31'h0, reg_rvalid});
    v = reg_rdata;
  endtask
  task automatic wait_busy(input logic v);
    for (int i = 0; i < 100 && nvm_busy !== v; i++) @(negedge clk);
    chk("nvm_busy", {31'h0, v}, {31'h0, nvm_busy});
    if (nvm_busy !== v) close_out();
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    chk("ao1_rst", `MDC_RST_DAC1, ao1);
    chk("ao2_rst", `MDC_RST_DAC2, ao2);
    rd(`MDC_OFS_ANALOG_OUT_CHANNEL_ONE, d);
    chk("dac1_rd", `MDC_RST_DAC1, d);
    rd(`MDC_OFS_DEVICE_COMMAND_CONTROL, d);
    chk("cmd_rst", `MDC_RST_CMD, d);
    // write-only word must read zero even after being written
    wr(`MDC_OFS_ALGORITHM_DEBUG_OVERRIDE_A, 32'hffff_ffff);
    rd(`MDC_OFS_ALGORITHM_DEBUG_OVERRIDE_A, d);
    chk("wo_rd", 32'h0, d);
    rd(`MDC_OFS_ANALOG_OUT_CHANNEL_TWO, d);
    chk("dac2_rd", `MDC_RST_DAC2, d);
    rd(8'he0, d);
    chk("unmapped_rd", 32'h0, d);
  endtask
  task automatic t_save_restore();
    wr(`MDC_OFS_CURRENT_LOOP_GAINS, 32'h1234_5678);
    wr(`MDC_OFS_SPEED_LOOP_GAINS, 32'h0bad_f00d);
    wr(`MDC_OFS_ALGORITHM_DEBUG_OVERRIDE_B, 32'hcafe_0001);
    wr(`MDC_OFS_DEVICE_COMMAND_CONTROL, 32'h8000_0000);
    rd(`MDC_OFS_DEVICE_COMMAND_CONTROL, d);
    chk("save_bit", 32'h1, {31'h0, d[31]});
    wait_busy(1'b0);
    rd(`MDC_OFS_DEVICE_COMMAND_CONTROL, d);
    chk("save_done", 32'h0, {31'h0, d[31]});
    chk("nvm_w0", 32'hcafe_0001, nvm.mem[0]);
    chk("nvm_w1", 32'h1234_5678, nvm.mem[1]);
    chk("nvm_w2", 32'h0bad_f00d, nvm.mem[2]);
    wr(`MDC_OFS_CURRENT_LOOP_GAINS, 32'h0);
    wr(`MDC_OFS_SPEED_LOOP_GAINS, 32'h0);
    wr(`MDC_OFS_DEVICE_COMMAND_CONTROL, 32'h4000_0000);
    wait_busy(1'b1);
    rd(`MDC_OFS_DEVICE_COMMAND_CONTROL, d);
    chk("load_bit", 32'h1, {31'h0, d[30]});
    wait_busy(1'b0);
    chk("cur_restored", 32'h1234_5678, cur_g);
    chk("spd_restored", 32'h0bad_f00d, spd_g);
    chk("dbg_restored", 32'hcafe_0001, dbg_b);
    rd(`MDC_OFS_DEVICE_COMMAND_CONTROL, d);
    chk("load_done", 32'h0, {31'h0, d[30]});
    // both command bits at once: save outranks restore
    wr(`MDC_OFS_DEVICE_COMMAND_CONTROL, 32'hc000_0000);
    rd(`MDC_OFS_DEVICE_COMMAND_CONTROL, d);
    chk("save_wins", 32'h2, {30'h0, d[31:30]});
    wait_busy(1'b0);
  endtask
  task automatic t_faults();
    wr(`MDC_OFS_DEVICE_COMMAND_CONTROL, 32'h2000_0000);
    chk("flt_pulse", 32'h2, {30'h0, flt_clr, rty_clr});
    wr(`MDC_OFS_DEVICE_COMMAND_CONTROL, 32'h1000_0000);
    chk("rty_pulse", 32'h1, {30'h0, flt_clr, rty_clr});
    rd(`MDC_OFS_DEVICE_COMMAND_CONTROL, d);
    chk("clr_nostore", 32'h0, {30'h0, d[29:28]});
  endtask
  task automatic t_tickle();
    // host refresh; the read rides right behind the write to see the bit set
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = `MDC_OFS_DEVICE_COMMAND_CONTROL;
    reg_wdata = 32'h0000_0400;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk("tickle_read", 32'h1, {31'h0, reg_rdata[10]});
    chk("wdog_pulse", 32'h1, {31'h0, wdog});
    rd(`MDC_OFS_DEVICE_COMMAND_CONTROL, d);
    chk("tickle_self_clr", 32'h0, {31'h0, d[10]});
  endtask
  task automatic t_angle();
    logic [8:0] a_in [4] = '{9'h190, 9'h167, 9'h168, 9'h1ff};
    logic [8:0] a_ex [4] = '{9'h028, 9'h167, 9'h000, 9'h097};
    force_align_en = 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(`MDC_OFS_DEVICE_COMMAND_CONTROL, {12'h0, a_in[i], 11'h0});
      repeat (3) @(negedge clk);
      chk("angle", {23'h0, a_ex[i]}, {23'h0, ang});
      chk("angle_valid", 32'h1, {31'h0, ang_v});
    end
    force_align_en = 1'b0;
    @(negedge clk);
    chk("angle_valid_off", 32'h0, {31'h0, ang_v});
  endtask
  task automatic t_midrun_reset();
    wr(`MDC_OFS_ANALOG_OUT_CHANNEL_ONE, 32'h0000_00aa);
    @(negedge clk);
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    chk("cur_rst", 32'h0, cur_g);
    t_reset();
  endtask
  // ==========================================================
  // main sequence; only listed offsets are ever written
  initial begin
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    t_reset();
    t_save_restore();
    t_faults();
    t_tickle();
    t_angle();
    t_midrun_reset();
    close_out();
  end
endmodule // tb_top
